// ===== logic/prl_defines.vh
// Register offsets, field positions, reset values and FIFO sizes for the pixel routing block
`ifndef PRL_DEFINES_VH
`define PRL_DEFINES_VH

// Offsets are word indices: each register owns one aligned word at four times its index
`define PRL_OFF_LINK_CFG 8'h18
`define PRL_OFF_ROUTE 8'h1a
`define PRL_OFF_CM_TRIM 8'h1b
`define PRL_OFF_LINE_LO 8'h20
`define PRL_OFF_LINE_HI 8'h21
`define PRL_OFF_CHAN_MODE 8'h10
`define PRL_OFF_STATUS 8'h40
`define PRL_OFF_PIX_CFG 8'h44

`define PRL_BIT_LINK_SINGLE 4
`define PRL_BIT_PARITY_SWAP 6
`define PRL_BIT_FLIP_A 5
`define PRL_BIT_FLIP_B 4
`define PRL_BIT_TERM_A 1
`define PRL_BIT_TERM_B 0
`define PRL_CHMODE_LSB 5

`define PRL_RST_LINK_CFG 8'h10
`define PRL_RST_ROUTE 8'h03
`define PRL_RST_CM_TRIM 8'h00
`define PRL_RST_LINE_LO 8'h00
`define PRL_RST_LINE_HI 8'h00
`define PRL_RST_CHAN_MODE 8'h20
`define PRL_MASK_ROUTE 8'h73
`define PRL_MASK_CM_TRIM 8'h33
`define PRL_MASK_LINE_HI 8'h0f
`define PRL_MASK_CHAN_MODE 8'h60
`define PRL_MASK_LINK_CFG 8'h1f

`define PRL_MODE_ODDEVEN 2'b00
`define PRL_MODE_LEFTRIGHT 2'b01
`define PRL_MODE_TWOSTREAM 2'b10
`define PRL_MODE_SINGLE 2'b11

`define PRL_CLK_SLOT 7'h63

`define PRL_FIFO_DEPTH 8
`define PRL_FIFO_AW 3
`define PRL_PIX_W 24

`endif

// ===== logic/prl_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module prl_fifo #(
   parameter WIDTH = 26,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire sys_clk,
   input wire rst,
   input wire clkEn,
   input wire [WIDTH-1:0] inData,
   input wire inValid,
   output wire inReady,
   output reg [WIDTH-1:0] outData_q,
   output reg outValid_q,
   input wire outReady
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wrPtr_q;
   reg [AW:0] rdPtr_q;
   wire [AW:0] count;
   wire full;
   wire memEmpty;
   wire push;
   wire pop;

   assign count = wrPtr_q - rdPtr_q;
   assign full = (count == DEPTH[AW:0]);
   assign memEmpty = (count == {(AW+1){1'b0}});
   assign inReady = ~full;
   assign push = inValid & ~full;
   // Output register refills whenever it is empty or being taken
   assign pop = ~memEmpty & (~outValid_q | outReady);

   always @(posedge sys_clk) begin
      if (clkEn && push) begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= {(AW+1){1'b0}};
         rdPtr_q <= {(AW+1){1'b0}};
         outData_q <= {WIDTH{1'b0}};
         outValid_q <= 1'b0;
      end else if (clkEn) begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
            outData_q <= mem[rdPtr_q[AW-1:0]];
            outValid_q <= 1'b1;
         end else if (outReady) begin
            outValid_q <= 1'b0;
         end
      end
   end
endmodule // prl_fifo

// ===== logic/prl_pixel_route.v
// Pixel routing, lane order and line length configuration with APB registers
//
// Function
// - Parity swap clear: odd pixels to output A, even to B; set reverses.
// - Two-stream with swap set: input A stream to output B, B to A.
// - Output A flip: lane 0 swaps lane 3, lane 1 swaps clock, lane 2 kept.
// - Output B flip: lane 0 swaps lane 3, lane 1 swaps clock, lane 2 kept.
// - First line length is 12 bits; low register gives bits 7..0.
// - Single input: first line length is full active pixels per line.
// - Odd/even: line length counts odd pixels from input A.
// - Left/right: line length counts left-half pixels from input A to output A.
// - Two-stream: line length counts pixels of input A stream to output A.
// - Channel B timing used only with both outputs on and two-stream mode.
// - Pattern generator uses channel A timing outside two-stream; never sync delay.
// - Upper four line length bits come from bits 3..0 of next register.
// - Link bit clear enables both outputs; set enables only output A.
`timescale 1ns/1ps
`include "prl_defines.vh"
module prl_pixel_route (
   input wire sys_clk,
   input wire rst,
   input wire clkEn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [9:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata_q,
   output wire pslverr,
   // Pixel link, sampled on sys_clk and taken on each detected link clock rise
   input wire linkClk,
   input wire [23:0] pixInA,
   input wire [23:0] pixInB,
   input wire pixLineStart,
   output wire pixInReady,
   // Output lanes, each a 7-bit serial slot word per lane
   output reg [6:0] outALane0_q,
   output reg [6:0] outALane1_q,
   output reg [6:0] outALane2_q,
   output reg [6:0] outALane3_q,
   output reg [6:0] outAClk_q,
   output reg [6:0] outBLane0_q,
   output reg [6:0] outBLane1_q,
   output reg [6:0] outBLane2_q,
   output reg [6:0] outBLane3_q,
   output reg [6:0] outBClk_q,
   output wire outAEnable,
   output wire outBEnable,
   output reg lineDone_q,
   output wire [11:0] activeLineLength,
   output wire useChanBTiming,
   output wire patternUsesChanA
);
   ////////////////////////////////////////////////////////////////////////
   // Registers
   reg [7:0] linkCfg_q;
   reg [7:0] route_q;
   reg [7:0] cmTrim_q;
   reg [7:0] lineLo_q;
   reg [7:0] lineHi_q;
   reg [7:0] chanMode_q;
   reg [7:0] pixCfg_q;
   wire [1:0] chanMode;
   wire paritySwap;
   wire flipA;
   wire flipB;
   wire linkSingle;
   wire twoStream;
   wire wrEn;
   wire rdEn;
   reg [31:0] rdMux;
   reg addrHit;
   reg [11:0] lineCount_q;
   wire [7:0] regIdx;
   wire alignOk;

   assign chanMode = chanMode_q[`PRL_CHMODE_LSB+1:`PRL_CHMODE_LSB];
   assign paritySwap = route_q[`PRL_BIT_PARITY_SWAP];
   assign flipA = route_q[`PRL_BIT_FLIP_A];
   assign flipB = route_q[`PRL_BIT_FLIP_B];
   assign linkSingle = linkCfg_q[`PRL_BIT_LINK_SINGLE];
   assign twoStream = (chanMode == `PRL_MODE_TWOSTREAM);

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   // Each register owns one aligned word, so the offsets act as word indices
   assign regIdx = paddr[9:2];
   // Low address bits are not byte lanes here; a stray one misses every register
   assign alignOk = (paddr[1:0] == 2'b00);

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake
   // Zero wait state slave
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addrHit;
   assign wrEn = psel & penable & pwrite & addrHit;
   assign rdEn = psel & ~penable & ~pwrite;

   ////////////////////////////////////////////////////////////////////////
   // Read path
   always @* begin
      addrHit = alignOk;
      rdMux = 32'h0;
      case (regIdx)
         `PRL_OFF_LINK_CFG: rdMux = {24'h0, linkCfg_q};
         `PRL_OFF_ROUTE: rdMux = {24'h0, route_q};
         `PRL_OFF_CM_TRIM: rdMux = {24'h0, cmTrim_q};
         `PRL_OFF_LINE_LO: rdMux = {24'h0, lineLo_q};
         `PRL_OFF_LINE_HI: rdMux = {24'h0, lineHi_q};
         `PRL_OFF_CHAN_MODE: rdMux = {24'h0, chanMode_q};
         `PRL_OFF_PIX_CFG: rdMux = {24'h0, pixCfg_q};
         `PRL_OFF_STATUS: rdMux = {20'h0, lineCount_q};
         default: addrHit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         linkCfg_q <= `PRL_RST_LINK_CFG;
         route_q <= `PRL_RST_ROUTE;
         cmTrim_q <= `PRL_RST_CM_TRIM;
         lineLo_q <= `PRL_RST_LINE_LO;
         lineHi_q <= `PRL_RST_LINE_HI;
         chanMode_q <= `PRL_RST_CHAN_MODE;
         pixCfg_q <= 8'h0;
         prdata_q <= 32'h0;
      end else if (clkEn) begin
         if (rdEn) begin
            prdata_q <= rdMux;
         end
         if (wrEn) begin
            case (regIdx)
               `PRL_OFF_LINK_CFG: linkCfg_q <= pwdata[7:0] & `PRL_MASK_LINK_CFG;
               `PRL_OFF_ROUTE: route_q <= pwdata[7:0] & `PRL_MASK_ROUTE;
               `PRL_OFF_CM_TRIM: cmTrim_q <= pwdata[7:0] & `PRL_MASK_CM_TRIM;
               `PRL_OFF_LINE_LO: lineLo_q <= pwdata[7:0];
               `PRL_OFF_LINE_HI: lineHi_q <= pwdata[7:0] & `PRL_MASK_LINE_HI;
               `PRL_OFF_CHAN_MODE: chanMode_q <= pwdata[7:0] & `PRL_MASK_CHAN_MODE;
               `PRL_OFF_PIX_CFG: pixCfg_q <= pwdata[7:0];
               default: pixCfg_q <= pixCfg_q;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Derived controls
   // Low byte gives bits 7..0, next register bits 3..0 the top nibble
   assign activeLineLength = {lineHi_q[3:0], lineLo_q};

   // Dual link unless single-link bit set
   assign outAEnable = 1'b1;
   assign outBEnable = ~linkSingle;

   // Channel B timing only for two-stream with both outputs on
   assign useChanBTiming = twoStream & ~linkSingle;
   // Sync delay never feeds the pattern generator, so only A/B select here
   assign patternUsesChanA = ~useChanBTiming;

   ////////////////////////////////////////////////////////////////////////
   // Link clock sampling and edge detect
   reg linkSync1_q;
   reg linkSync2_q;
   reg linkPrev_q;
   reg [23:0] pixASync1_q;
   reg [23:0] pixASync2_q;
   reg [23:0] pixBSync1_q;
   reg [23:0] pixBSync2_q;
   reg startSync1_q;
   reg startSync2_q;
   wire linkRise;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         linkSync1_q <= 1'b0;
         linkSync2_q <= 1'b0;
         linkPrev_q <= 1'b0;
         pixASync1_q <= 24'h0;
         pixASync2_q <= 24'h0;
         pixBSync1_q <= 24'h0;
         pixBSync2_q <= 24'h0;
         startSync1_q <= 1'b0;
         startSync2_q <= 1'b0;
      end else if (clkEn) begin
         linkSync1_q <= linkClk;
         linkSync2_q <= linkSync1_q;
         linkPrev_q <= linkSync2_q;
         pixASync1_q <= pixInA;
         pixASync2_q <= pixASync1_q;
         pixBSync1_q <= pixInB;
         pixBSync2_q <= pixBSync1_q;
         startSync1_q <= pixLineStart;
         startSync2_q <= startSync1_q;
      end
   end

   // Data sampled two stages late matches the delayed clock edge
   assign linkRise = linkSync2_q & ~linkPrev_q;

   ////////////////////////////////////////////////////////////////////////
   // Steering into the output FIFO
   reg [23:0] toA;
   reg [23:0] toB;
   reg [11:0] lineTarget;
   wire [11:0] countBase;
   wire pixTaken;
   wire [47:0] fifoOut;
   wire fifoOutValid;
   wire fifoInReady;
   wire lineEnd;

   always @* begin
      // Odd/even and left/right: A input carries odd or left pixels
      if (paritySwap) begin
         toA = pixBSync2_q;
         toB = pixASync2_q;
      end else begin
         toA = pixASync2_q;
         toB = pixBSync2_q;
      end
   end

   always @* begin
      // All arrangements count input A pixels against the first length
      case (chanMode)
         `PRL_MODE_SINGLE: lineTarget = activeLineLength;
         `PRL_MODE_ODDEVEN: lineTarget = activeLineLength;
         `PRL_MODE_LEFTRIGHT: lineTarget = activeLineLength;
         `PRL_MODE_TWOSTREAM: lineTarget = activeLineLength;
         default: lineTarget = activeLineLength;
      endcase
   end

   assign pixInReady = fifoInReady;
   assign pixTaken = linkRise & fifoInReady;
   // The line-start pixel is itself the first pixel of the count
   assign countBase = startSync2_q ? 12'h0 : lineCount_q;
   // A zero length never ends a line, so the counter just wraps
   assign lineEnd = pixTaken & (lineTarget != 12'h0) & (countBase == lineTarget - 12'h1);

   ////////////////////////////////////////////////////////////////////////
   // Line counter
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lineCount_q <= 12'h0;
         lineDone_q <= 1'b0;
      end else if (clkEn) begin
         lineDone_q <= lineEnd;
         if (lineEnd) begin
            lineCount_q <= 12'h0;
         end else if (pixTaken) begin
            lineCount_q <= countBase + 12'h1;
         end else if (linkRise && startSync2_q) begin
            // A dropped start pixel still restarts the line
            lineCount_q <= 12'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output FIFO
   prl_fifo #(
      .WIDTH(48),
      .DEPTH(`PRL_FIFO_DEPTH),
      .AW(`PRL_FIFO_AW)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .inData({toB, toA}),
      .inValid(linkRise),
      .inReady(fifoInReady),
      .outData_q(fifoOut),
      .outValid_q(fifoOutValid),
      // Lanes take a word every cycle, so the FIFO output never stalls
      .outReady(1'b1)
   );

   ////////////////////////////////////////////////////////////////////////
   // Lane mapping with optional reversal per output
   // Index 0 is output A, index 1 output B
   wire [34:0] slotWord [0:1];
   wire [1:0] flipSel;
   wire [1:0] chanOn;
   wire [6:0] lane0_d [0:1];
   wire [6:0] lane1_d [0:1];
   wire [6:0] lane2_d [0:1];
   wire [6:0] lane3_d [0:1];
   wire [6:0] clkSlot_d [0:1];
   genvar ch;

   assign slotWord[0] = {fifoOut[23:0], 4'h0, fifoOut[2:0], 4'h0};
   assign slotWord[1] = {fifoOut[47:24], 4'h0, fifoOut[26:24], 4'h0};
   assign flipSel = {flipB, flipA};
   assign chanOn = {outBEnable, outAEnable};

   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_lane
         wire [34:0] src;
         wire [6:0] clkWord;
         // A disabled output drives idle words on all five pairs
         assign src = chanOn[ch] ? slotWord[ch] : 35'h0;
         assign clkWord = chanOn[ch] ? `PRL_CLK_SLOT : 7'h0;
         // Flip trades lane 0 with lane 3 and lane 1 with the clock pair; lane 2 never moves
         assign lane0_d[ch] = flipSel[ch] ? src[13:7] : src[34:28];
         assign lane1_d[ch] = flipSel[ch] ? clkWord : src[27:21];
         assign lane2_d[ch] = src[20:14];
         assign lane3_d[ch] = flipSel[ch] ? src[34:28] : src[13:7];
         assign clkSlot_d[ch] = flipSel[ch] ? src[27:21] : clkWord;
      end
   endgenerate

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         outALane0_q <= 7'h0;
         outALane1_q <= 7'h0;
         outALane2_q <= 7'h0;
         outALane3_q <= 7'h0;
         outAClk_q <= 7'h0;
         outBLane0_q <= 7'h0;
         outBLane1_q <= 7'h0;
         outBLane2_q <= 7'h0;
         outBLane3_q <= 7'h0;
         outBClk_q <= 7'h0;
      end else if (clkEn && fifoOutValid) begin
         outALane0_q <= lane0_d[0];
         outALane1_q <= lane1_d[0];
         outALane2_q <= lane2_d[0];
         outALane3_q <= lane3_d[0];
         outAClk_q <= clkSlot_d[0];
         outBLane0_q <= lane0_d[1];
         outBLane1_q <= lane1_d[1];
         outBLane2_q <= lane2_d[1];
         outBLane3_q <= lane3_d[1];
         outBClk_q <= clkSlot_d[1];
      end
   end
endmodule // prl_pixel_route

// ===== dv/prl_route_checker.sv
// Assertion checker for the pixel routing block
`timescale 1ns/1ps
module prl_route_checker (
   input wire sys_clk,
   input wire rst,
   input wire clkEn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [9:0] paddr,
   input wire [31:0] pwdata,
   input wire outAEnable,
   input wire outBEnable,
   input wire [11:0] activeLineLength,
   input wire useChanBTiming,
   input wire patternUsesChanA
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic linkCfg_q;
   logic [1:0] mode_q;
   wire wrEn = psel && penable && pwrite && clkEn;
   // Mirror of link and mode fields, fed only from bus writes
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         linkCfg_q <= 1'b1;
         mode_q <= 2'b01;
      end else if (wrEn && paddr == 10'h060) begin
         linkCfg_q <= pwdata[4];
      end else if (wrEn && paddr == 10'h040) begin
         mode_q <= pwdata[6:5];
      end
   end
   sequence s_wr(a); wrEn && paddr == a; endsequence
   property p_len_lo; s_wr(10'h080) |=> activeLineLength[7:0] == $past(pwdata[7:0]); endproperty
   a_len_lo: assert property (p_len_lo) else $error("low length byte lost");
   property p_len_hi; s_wr(10'h084) |=> activeLineLength[11:8] == $past(pwdata[3:0]); endproperty
   a_len_hi: assert property (p_len_hi) else $error("high length bits lost");
   property p_len_keep; !(wrEn && paddr[9:3] == 7'h10) |=> $stable(activeLineLength); endproperty
   a_len_keep: assert property (p_len_keep) else $error("length moved without write");
   property p_link_wr; s_wr(10'h060) |=> outBEnable == !$past(pwdata[4]); endproperty
   a_link_wr: assert property (p_link_wr) else $error("B enable ignores link write");
   property p_link; outAEnable && outBEnable == !linkCfg_q; endproperty
   a_link: assert property (p_link) else $error("output enables wrong");
   property p_chanb; useChanBTiming == (mode_q == 2'b10 && !linkCfg_q); endproperty
   a_chanb: assert property (p_chanb) else $error("B timing use wrong");
   property p_pattern; patternUsesChanA == !(mode_q == 2'b10 && !linkCfg_q); endproperty
   a_pattern: assert property (p_pattern) else $error("pattern timing source wrong");
   property p_reset; $past(rst) |-> activeLineLength == 12'h000 && !outBEnable && patternUsesChanA; endproperty
   a_reset: assert property (p_reset) else $error("state after reset wrong");
endmodule // prl_route_checker
bind prl_pixel_route prl_route_checker u_chk (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .outAEnable(outAEnable),
   .outBEnable(outBEnable), .activeLineLength(activeLineLength), .useChanBTiming(useChanBTiming),
   .patternUsesChanA(patternUsesChanA));

// ===== dv/prl_host_model.sv
// Video host model driving the pixel link
`timescale 1ns/1ps
module prl_host_model (
   output logic linkClk,
   output logic [23:0] pixInA,
   output logic [23:0] pixInB,
   output logic pixLineStart
);
   initial begin
      linkClk = 1'b0;
      pixInA = 24'h5a5a5a;
      pixInB = 24'ha5a5a5;
      pixLineStart = 1'b0;
   end
   // Clock stands still between lines; stale data is inverted so it never looks valid
   task automatic send_line(input int n, input logic [23:0] seed);
      for (int i = 0; i < n; i++) begin
         pixInA = seed + 24'(3 * i);
         pixInB = ~seed - 24'(5 * i);
         pixLineStart = (i == 0);
         #80 linkClk = 1'b1;
         #80 linkClk = 1'b0;
      end
      pixLineStart = 1'b0;
      pixInA = ~pixInA;
      pixInB = ~pixInB;
   endtask
endmodule // prl_host_model

// ===== dv/pixel_route_line_length_cfg_tb_top.sv
// Testbench for the pixel routing block
`timescale 1ns/1ps
module pixel_route_line_length_cfg_tb_top;
   logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [69:0] base;
   logic [7:0] addrs [6] = '{8'h1a, 8'h1b, 8'h20, 8'h21, 8'h18, 8'h10};
   logic [7:0] rstv [6] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h10, 8'h20};
   logic [7:0] mask [6] = '{8'h73, 8'h33, 8'hff, 8'h0f, 8'h1f, 8'h60};
   wire pready, pslverr, linkClk, pixLineStart, outAEnable, outBEnable, lineDone_q, useChanBTiming, patternUsesChanA;
   wire [31:0] prdata_q;
   wire pixInReady;
   wire [23:0] pixInA, pixInB;
   wire [11:0] activeLineLength;
   wire [6:0] aL0, aL1, aL2, aL3, aCk, bL0, bL1, bL2, bL3, bCk;
   wire [69:0] now = {aL0, aL1, aL2, aL3, aCk, bL0, bL1, bL2, bL3, bCk};
   int miscompares = 0, comparisons = 0, dones = 0;
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (lineDone_q === 1'b1) dones++;
   prl_pixel_route u_dut (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata_q(prdata_q), .pslverr(pslverr),
      .linkClk(linkClk), .pixInA(pixInA), .pixInB(pixInB), .pixLineStart(pixLineStart), .pixInReady(pixInReady),
      .outALane0_q(aL0), .outALane1_q(aL1), .outALane2_q(aL2), .outALane3_q(aL3), .outAClk_q(aCk),
      .outBLane0_q(bL0), .outBLane1_q(bL1), .outBLane2_q(bL2), .outBLane3_q(bL3), .outBClk_q(bCk),
      .outAEnable(outAEnable), .outBEnable(outBEnable), .lineDone_q(lineDone_q),
      .activeLineLength(activeLineLength), .useChanBTiming(useChanBTiming), .patternUsesChanA(patternUsesChanA));
   prl_host_model u_host (.linkClk(linkClk), .pixInA(pixInA), .pixInB(pixInB), .pixLineStart(pixLineStart));
   ////////////////////////////////////////
   function automatic logic [34:0] flip(input logic [34:0] x);
      return {x[13:7], x[6:0], x[20:14], x[34:28], x[27:21]};
   endfunction
   task automatic chk(input string what, input logic [69:0] seen, input logic [69:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // One transfer, then an idle edge so back-to-back calls never drive psel twice at once
   task automatic apb(input logic [9:0] a, input logic w, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) begin
         miscompares++;
         close_out();
      end
      rd = prdata_q;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic line();
      u_host.send_line(4, 24'h3c5a17);
      repeat (20) @(posedge sys_clk);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      foreach (addrs[i]) begin
         apb({addrs[i], 2'b00}, 1'b0, 32'h0);
         chk("reset value", rd, rstv[i]);
         apb({addrs[i], 2'b00}, 1'b1, 32'hff);
         apb({addrs[i], 2'b00}, 1'b0, 32'h0);
         chk("write mask", rd, mask[i]);
      end
      chk("full length", activeLineLength, 12'hfff);
      apb(10'h0c0, 1'b1, 32'hff);
      apb(10'h0c0, 1'b0, 32'h0);
      chk("unmapped", {err, rd}, {1'b1, 32'h0});
      apb(10'h081, 1'b1, 32'h0);
      chk("unaligned", {err, activeLineLength}, {1'b1, 12'hfff});
      for (int m = 0; m < 4; m++)
         for (int l = 0; l < 2; l++) begin
            apb(10'h040, 1'b1, 32'(m << 5));
            apb(10'h060, 1'b1, 32'(l << 4));
            chk("B timing", useChanBTiming, m == 2 && l == 0);
            chk("pattern on A", patternUsesChanA, !(m == 2 && l == 0));
            chk("enables", {outAEnable, outBEnable}, {1'b1, l == 0});
         end
      apb(10'h080, 1'b1, 32'h04);
      apb(10'h084, 1'b1, 32'h00);
      for (int m = 0; m < 4; m++) begin
         apb(10'h040, 1'b1, 32'(m << 5));
         dones = 0;
         line();
         chk("line done count", dones, 1);
      end
      chk("input ready", pixInReady, 1'b1);
      apb(10'h060, 1'b1, 32'h00);
      // Odd/even first, then two streams
      for (int k = 0; k < 2; k++) begin
         apb(10'h040, 1'b1, 32'(k << 6));
         for (int s = 0; s < 2; s++) begin
            apb(10'h068, 1'b1, 32'(s << 6));
            line();
            if (s == 0) base = now;
         end
         chk("swapped outputs", now, {base[34:0], base[69:35]});
      end
      chk("A clock slot", base[41:35], 7'h63);
      for (int f = 0; f < 2; f++) begin
         apb(10'h068, 1'b1, f ? 32'h10 : 32'h20);
         line();
         chk("A lanes", now[69:35], f ? base[69:35] : flip(base[69:35]));
         chk("B lanes", now[34:0], f ? flip(base[34:0]) : base[34:0]);
      end
      close_out();
   end
endmodule // pixel_route_line_length_cfg_tb_top
